// [hw/dbc_bank_rules.sv]
// Bank state tracker and command legality checker for a low-power DDR SDRAM
`timescale 1ns/1ps
module dbc_bank_rules
  import dbc_pkg::*;
#(
  parameter int NUM_BANKS = 8,
  parameter int BANK_W    = 3,
  parameter int DATA_W    = 32
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              nrst,
  // Command
  input  wire dbc_cmd_e          cmd,
  input  wire logic [BANK_W-1:0] cmdBank,
  input  wire logic              autoPrecharge,
  // Write data beat
  input  wire logic              wrBeat,
  input  wire logic [DATA_W-1:0] wrData,
  input  wire logic              writeMask,
  // Outputs
  output logic                   illegalCmd,
  output logic                   wrStrobe,
  output logic [DATA_W-1:0]      wrDataOut,
  output logic                   allIdle,
  output logic                   mrBusy,
  output dbc_dev_e               devState
);
  dbc_bank_e              bankState [NUM_BANKS];
  logic [CNT_W-1:0]       bankCnt   [NUM_BANKS];
  logic [NUM_BANKS-1:0]   bankAuto;
  logic [CNT_W-1:0]       mrCnt;
  logic [CNT_W-1:0]       rrdCnt;
  logic                   burstOn;
  logic [BANK_W-1:0]      burstBank;
  logic                   anyBurst;
  logic                   anyOpening;
  logic                   illegal;
  dbc_bank_e              sel;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n);
  endfunction

  always_comb begin
    allIdle = 1'b1;
    anyBurst = 1'b0;
    anyOpening = 1'b0;
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (bankState[i] != DBC_IDLE) allIdle = 1'b0;
      if (bankState[i] == DBC_ACTIVATING) anyOpening = 1'b1;
      if (bankState[i] == DBC_READING || bankState[i] == DBC_WRITING) anyBurst = 1'b1;
    end
  end

  assign sel    = bankState[cmdBank];
  assign mrBusy = (devState == DBC_MR_READING) || (devState == DBC_MR_WRITING);

  // Legality of the incoming command
  always_comb begin
    illegal = 1'b0;
    if (mrBusy) begin
      illegal = (cmd != DBC_NOP);
    end else if (devState == DBC_POWER_ON) begin
      illegal = (cmd != DBC_NOP) && (cmd != DBC_MODE_REG_RESET);
    end else if (devState == DBC_RESETTING) begin
      illegal = (cmd != DBC_NOP) && (cmd != DBC_MODE_REG_READ);
    end else begin
      case (cmd)
        DBC_NOP:            illegal = 1'b0;
        DBC_ACTIVATE:       illegal = (sel != DBC_IDLE) || (rrdCnt != CNT_ZERO);
        DBC_READ:           illegal = (sel != DBC_ACTIVE && sel != DBC_READING) || bankAuto[cmdBank] ||
                                      (anyBurst && !(burstBank == cmdBank && sel == DBC_READING));
        DBC_WRITE:          illegal = (sel != DBC_ACTIVE && sel != DBC_WRITING) || bankAuto[cmdBank] ||
                                      (anyBurst && !(burstBank == cmdBank && sel == DBC_WRITING));
        DBC_PRECHARGE:      illegal = (sel == DBC_ACTIVATING) || bankAuto[cmdBank];
        DBC_PRECHARGE_ALL:  illegal = (|bankAuto) || anyBurst || anyOpening;
        DBC_BURST_TERMINATE: illegal = !burstOn || burstBank != cmdBank || bankAuto[cmdBank] ||
                                       (sel != DBC_READING && sel != DBC_WRITING);
        DBC_MODE_REG_READ:  illegal = anyBurst;
        DBC_MODE_REG_WRITE, DBC_MODE_REG_RESET, DBC_REFRESH, DBC_SELF_REFRESH:
                            illegal = !allIdle || anyBurst;
        default:            illegal = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) illegalCmd <= 1'b0;
    else illegalCmd <= illegal;
  end

  // Device level state and mode register windows
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      devState <= DBC_POWER_ON;
      mrCnt <= CNT_ZERO;
    end else if (mrBusy) begin
      if (mrCnt == CNT_ONE) devState <= DBC_NORMAL;
      mrCnt <= mrCnt - CNT_ONE;
    end else if (!illegal) begin
      if (devState == DBC_POWER_ON && cmd == DBC_MODE_REG_RESET) begin
        devState <= DBC_RESETTING;
      end else if (cmd == DBC_MODE_REG_READ) begin
        devState <= DBC_MR_READING;
        mrCnt <= cyc(MODE_READ_CYC);
      end else if (devState == DBC_NORMAL &&
                   (cmd == DBC_MODE_REG_WRITE || cmd == DBC_MODE_REG_RESET)) begin
        devState <= DBC_MR_WRITING;
        mrCnt <= cyc(MODE_WRITE_CYC);
      end
    end
  end

  // Activate-to-activate spacing
  always_ff @(posedge mclk) begin
    if (!nrst) rrdCnt <= CNT_ZERO;
    else if (!illegal && !mrBusy && devState == DBC_NORMAL && cmd == DBC_ACTIVATE) begin
      rrdCnt <= cyc(ACT_ACT_CYC) - CNT_ONE;
    end
    else if (rrdCnt != CNT_ZERO) rrdCnt <= rrdCnt - CNT_ONE;
  end

  // Most recent burst owner
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      burstOn <= 1'b0;
      burstBank <= '0;
    end else if (!illegal && devState == DBC_NORMAL && (cmd == DBC_READ || cmd == DBC_WRITE)) begin
      burstOn <= 1'b1;
      burstBank <= cmdBank;
    end else if (!anyBurst || (!illegal && cmd == DBC_BURST_TERMINATE)) begin
      burstOn <= 1'b0;
    end
  end

  // Per bank state machines; mode register windows freeze them
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    logic hit;
    assign hit = !illegal && !mrBusy && devState == DBC_NORMAL &&
                 (cmdBank == BANK_W'(b) || cmd == DBC_PRECHARGE_ALL);
    always_ff @(posedge mclk) begin
      if (!nrst) begin
        bankState[b] <= DBC_IDLE;
        bankCnt[b] <= CNT_ZERO;
        bankAuto[b] <= 1'b0;
      end else if (hit && cmd == DBC_ACTIVATE) begin
        bankState[b] <= DBC_ACTIVATING;
        bankCnt[b] <= cyc(ACT_ACCESS_CYC);
      end else if (hit && (cmd == DBC_READ || cmd == DBC_WRITE)) begin
        bankState[b] <= (cmd == DBC_READ) ? DBC_READING : DBC_WRITING;
        bankCnt[b] <= cyc(BURST_LEN / 2);
        bankAuto[b] <= autoPrecharge;
      end else if (hit && (cmd == DBC_PRECHARGE || cmd == DBC_PRECHARGE_ALL)) begin
        bankState[b] <= DBC_PRECHARGING;
        bankCnt[b] <= cyc(PRECHARGE_CYC);
      end else if (hit && cmd == DBC_BURST_TERMINATE) begin
        bankState[b] <= DBC_ACTIVE;
        bankCnt[b] <= CNT_ZERO;
      end else if (mrBusy) begin
        bankState[b] <= bankState[b];
      end else if (bankCnt[b] > CNT_ONE) begin
        bankCnt[b] <= bankCnt[b] - CNT_ONE;
      end else if (bankCnt[b] == CNT_ONE) begin
        bankCnt[b] <= CNT_ZERO;
        case (bankState[b])
          DBC_ACTIVATING:  bankState[b] <= DBC_ACTIVE;
          DBC_PRECHARGING: bankState[b] <= DBC_IDLE;
          DBC_READING, DBC_WRITING: begin
            if (bankAuto[b]) begin
              bankState[b] <= DBC_PRECHARGING;
              bankCnt[b] <= cyc(PRECHARGE_CYC);
              bankAuto[b] <= 1'b0;
            end else begin
              bankState[b] <= DBC_ACTIVE;
            end
          end
          default: bankState[b] <= bankState[b];
        endcase
      end
    end
  end

  // Masked write data path
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wrStrobe <= 1'b0;
      wrDataOut <= '0;
    end else begin
      wrStrobe <= wrBeat && !writeMask;
      if (wrBeat && !writeMask) wrDataOut <= wrData;
    end
  end

  property p_mode_only_nop;
    @(posedge mclk) disable iff (!nrst) mrBusy && cmd != DBC_NOP |=> illegalCmd;
  endproperty
  a_mode_only_nop: assert property (p_mode_only_nop) else $error("Command inside mode window not flagged");

  property p_mask;
    @(posedge mclk) disable iff (!nrst) wrBeat && writeMask |=> !wrStrobe;
  endproperty
  a_mask: assert property (p_mask) else $error("Masked beat was written");

  property p_unmask;
    @(posedge mclk) disable iff (!nrst) wrBeat && !writeMask |=> wrStrobe && wrDataOut == $past(wrData);
  endproperty
  a_unmask: assert property (p_unmask) else $error("Unmasked beat not written");

  property p_reset_enter;
    @(posedge mclk) disable iff (!nrst)
      devState == DBC_POWER_ON && cmd == DBC_MODE_REG_RESET |=> devState == DBC_RESETTING;
  endproperty
  a_reset_enter: assert property (p_reset_enter) else $error("Reset write did not start init");

  property p_mode_read_len;
    @(posedge mclk) disable iff (!nrst)
      $rose(devState == DBC_MR_READING) |-> (devState == DBC_MR_READING) [*2] ##1 devState == DBC_NORMAL;
  endproperty
  a_mode_read_len: assert property (p_mode_read_len) else $error("Mode read window wrong length");

  property p_mode_write_len;
    @(posedge mclk) disable iff (!nrst)
      $rose(devState == DBC_MR_WRITING) |-> (devState == DBC_MR_WRITING) [*5] ##1 devState == DBC_NORMAL;
  endproperty
  a_mode_write_len: assert property (p_mode_write_len) else $error("Mode write window wrong length");

  property p_mode_freeze;
    @(posedge mclk) disable iff (!nrst) mrBusy |=> bankState[0] == $past(bankState[0]);
  endproperty
  a_mode_freeze: assert property (p_mode_freeze) else $error("Bank moved during mode window");

  property p_bst_needs_burst;
    @(posedge mclk) disable iff (!nrst)
      devState == DBC_NORMAL && cmd == DBC_BURST_TERMINATE && !burstOn |=> illegalCmd;
  endproperty
  a_bst_needs_burst: assert property (p_bst_needs_burst) else $error("Idle terminate not flagged");

  property p_refresh_idle;
    @(posedge mclk) disable iff (!nrst)
      devState == DBC_NORMAL && !mrBusy && cmd == DBC_REFRESH && !allIdle |=> illegalCmd;
  endproperty
  a_refresh_idle: assert property (p_refresh_idle) else $error("Refresh with open bank not flagged");
endmodule

// [hw/dbc_pkg.sv]
// Package of command codes, bank states and timing counts for the bank command checker
package dbc_pkg;
  localparam int CLK_NS           = 40;
  localparam int PRECHARGE_NS     = 18;
  localparam int ACT_ACCESS_NS    = 18;
  localparam int MODE_READ_NS     = 80;
  localparam int MODE_WRITE_NS    = 200;
  localparam int ACT_ACT_NS       = 10;
  localparam int PRECHARGE_CYC    = (PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACT_ACCESS_CYC   = (ACT_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int MODE_READ_CYC    = (MODE_READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int MODE_WRITE_CYC   = (MODE_WRITE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACT_ACT_CYC      = (ACT_ACT_NS + CLK_NS - 1) / CLK_NS;
  localparam int BURST_LEN        = 4;
  localparam int CNT_W            = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;

  typedef enum logic [3:0] {
    DBC_NOP, DBC_ACTIVATE, DBC_READ, DBC_WRITE, DBC_PRECHARGE, DBC_PRECHARGE_ALL,
    DBC_BURST_TERMINATE, DBC_MODE_REG_READ, DBC_MODE_REG_WRITE, DBC_MODE_REG_RESET,
    DBC_REFRESH, DBC_SELF_REFRESH
  } dbc_cmd_e;

  typedef enum logic [2:0] {
    DBC_IDLE, DBC_ACTIVATING, DBC_ACTIVE, DBC_READING, DBC_WRITING, DBC_PRECHARGING
  } dbc_bank_e;

  typedef enum logic [2:0] {
    DBC_POWER_ON, DBC_RESETTING, DBC_NORMAL, DBC_MR_READING, DBC_MR_WRITING
  } dbc_dev_e;
endpackage

// [testbench/dbc_host_model.sv]
// Host controller model that places commands on the bank command inputs
`timescale 1ns/1ps
module dbc_host_model
  import dbc_pkg::*;
(
  // Clock and window status
  input  wire logic       mclk,
  input  wire logic       mrBusy,
  // Requests from the bench
  input  wire logic       lax,
  input  wire dbc_cmd_e   reqCmd,
  input  wire logic [2:0] reqBank,
  // Command bus
  output dbc_cmd_e        cmd,
  output logic [2:0]      cmdBank
);
  logic busyLatched;
  initial busyLatched = 1'h0;
  always @(negedge mclk) begin
    busyLatched <= mrBusy;
  end
  // Only NOPs inside a mode register window unless a break is ordered
  assign cmd     = (busyLatched && !lax) ? DBC_NOP : reqCmd;
  assign cmdBank = reqBank;
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the bank command checker
`timescale 1ns/1ps
module tb_top
  import dbc_pkg::*;
();
  typedef struct packed {dbc_cmd_e cmd; logic [2:0] bank; logic ill; dbc_dev_e dev; logic idle;} dbc_row_s;
  logic        mclk, nrst, lax, autoPre, wrBeat, writeMask, illegalCmd, wrStrobe, allIdle, mrBusy;
  dbc_cmd_e    reqCmd, cmd;
  logic [2:0]  reqBank, cmdBank;
  logic [31:0] wrData, wrDataOut;
  dbc_dev_e    devState;
  int          badCount, checks, cycles;
  dbc_row_s    rows [0:28];

  dbc_host_model u_dbc_host_model (.mclk(mclk), .mrBusy(mrBusy), .lax(lax), .reqCmd(reqCmd),
    .reqBank(reqBank), .cmd(cmd), .cmdBank(cmdBank));
  dbc_bank_rules u_dbc_bank_rules (.mclk(mclk), .nrst(nrst), .cmd(cmd), .cmdBank(cmdBank),
    .autoPrecharge(autoPre), .wrBeat(wrBeat), .wrData(wrData), .writeMask(writeMask),
    .illegalCmd(illegalCmd), .wrStrobe(wrStrobe), .wrDataOut(wrDataOut), .allIdle(allIdle),
    .mrBusy(mrBusy), .devState(devState));

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmpBit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      badCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmpDev(input dbc_dev_e got, input dbc_dev_e exp);
    checks++;
    if (got !== exp) begin
      badCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic drive(input dbc_cmd_e c, input logic [2:0] b, input logic a);
    reqCmd = c;
    reqBank = b;
    autoPre = a;
    @(negedge mclk);
  endtask

  task automatic cmpData(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      badCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 400) begin
      badCount++;
      tally_and_finish();
    end
  end

  initial begin
    nrst = 1'h0;
    lax = 1'h0;
    autoPre = 1'h0;
    reqCmd = DBC_NOP;
    reqBank = 3'h0;
    wrBeat = 1'h0;
    writeMask = 1'h0;
    wrData = 32'h0;
    badCount = 0;
    checks = 0;
    cycles = 0;
    rows = '{
      '{DBC_NOP, 3'h0, 1'h0, DBC_POWER_ON, 1'h1},
      '{DBC_ACTIVATE, 3'h0, 1'h1, DBC_POWER_ON, 1'h1},
      '{DBC_MODE_REG_RESET, 3'h0, 1'h0, DBC_RESETTING, 1'h1},
      '{DBC_MODE_REG_READ, 3'h0, 1'h0, DBC_MR_READING, 1'h1},
      '{DBC_ACTIVATE, 3'h1, 1'h1, DBC_MR_READING, 1'h1},
      '{DBC_NOP, 3'h0, 1'h0, DBC_NORMAL, 1'h1},
      '{DBC_BURST_TERMINATE, 3'h0, 1'h1, DBC_NORMAL, 1'h1},
      '{DBC_ACTIVATE, 3'h2, 1'h0, DBC_NORMAL, 1'h0},
      '{DBC_NOP, 3'h0, 1'h0, DBC_NORMAL, 1'h0},
      '{DBC_REFRESH, 3'h0, 1'h1, DBC_NORMAL, 1'h0},
      '{DBC_WRITE, 3'h2, 1'h0, DBC_NORMAL, 1'h0},
      '{DBC_READ, 3'h2, 1'h1, DBC_NORMAL, 1'h0},
      '{DBC_BURST_TERMINATE, 3'h2, 1'h0, DBC_NORMAL, 1'h0},
      '{DBC_READ, 3'h2, 1'h0, DBC_NORMAL, 1'h0},
      '{DBC_WRITE, 3'h2, 1'h1, DBC_NORMAL, 1'h0},
      '{DBC_NOP, 3'h0, 1'h0, DBC_NORMAL, 1'h0},
      '{DBC_MODE_REG_READ, 3'h0, 1'h0, DBC_MR_READING, 1'h0},
      '{DBC_NOP, 3'h0, 1'h0, DBC_MR_READING, 1'h0},
      '{DBC_NOP, 3'h0, 1'h0, DBC_NORMAL, 1'h0},
      '{DBC_MODE_REG_RESET, 3'h0, 1'h1, DBC_NORMAL, 1'h0},
      '{DBC_MODE_REG_WRITE, 3'h0, 1'h1, DBC_NORMAL, 1'h0},
      '{DBC_PRECHARGE_ALL, 3'h0, 1'h0, DBC_NORMAL, 1'hx},
      '{DBC_NOP, 3'h0, 1'h0, DBC_NORMAL, 1'h1},
      '{DBC_MODE_REG_WRITE, 3'h0, 1'h0, DBC_MR_WRITING, 1'h1},
      '{DBC_PRECHARGE, 3'h0, 1'h1, DBC_MR_WRITING, 1'h1},
      '{DBC_NOP, 3'h0, 1'h0, DBC_MR_WRITING, 1'h1},
      '{DBC_NOP, 3'h0, 1'h0, DBC_MR_WRITING, 1'h1},
      '{DBC_NOP, 3'h0, 1'h0, DBC_MR_WRITING, 1'h1},
      '{DBC_NOP, 3'h0, 1'h0, DBC_NORMAL, 1'h1}
    };
    repeat (10) @(negedge mclk);
    nrst = 1'h1;
    for (int i = 0; i < 29; i++) begin
      reqCmd = rows[i].cmd;
      reqBank = rows[i].bank;
      lax = rows[i].ill;
      @(negedge mclk);
      cmpBit(illegalCmd, rows[i].ill);
      cmpBit(wrStrobe, 1'h0);
      cmpDev(devState, rows[i].dev);
      cmpBit(mrBusy, rows[i].dev inside {DBC_MR_READING, DBC_MR_WRITING});
      if (rows[i].idle !== 1'hx) cmpBit(allIdle, rows[i].idle);
    end
    // Unmasked beat then masked beat
    reqCmd = DBC_NOP;
    lax = 1'h0;
    wrBeat = 1'h1;
    wrData = 32'h0badcafe;
    @(negedge mclk);
    cmpBit(wrStrobe, 1'h1);
    cmpData(wrDataOut, 32'h0badcafe);
    writeMask = 1'h1;
    wrData = 32'h5a5a5a5a;
    @(negedge mclk);
    cmpBit(wrStrobe, 1'h0);
    cmpData(wrDataOut, 32'h0badcafe);
    wrBeat = 1'h0;
    writeMask = 1'h0;
    // Open bank 1 for the auto precharge read below; bank 5, activated later, is the bank the mid-run reset finds open
    reqCmd = DBC_ACTIVATE;
    reqBank = 3'h1;
    @(negedge mclk);
    cmpBit(allIdle, 1'h0);
    // Back-to-back activates, precharge-all refusal, auto precharge, late terminate, mode read
    lax = 1'h1;
    drive(DBC_ACTIVATE, 3'h3, 1'h0);
    cmpBit(illegalCmd, 1'h0);
    drive(DBC_PRECHARGE_ALL, 3'h0, 1'h0);
    cmpBit(illegalCmd, 1'h1);
    drive(DBC_READ, 3'h1, 1'h1);
    cmpBit(illegalCmd, 1'h0);
    drive(DBC_ACTIVATE, 3'h5, 1'h0);
    cmpBit(illegalCmd, 1'h0);
    drive(DBC_PRECHARGE, 3'h1, 1'h0);
    cmpBit(illegalCmd, 1'h1);
    drive(DBC_BURST_TERMINATE, 3'h1, 1'h0);
    cmpBit(illegalCmd, 1'h1);
    drive(DBC_PRECHARGE, 3'h3, 1'h0);
    cmpBit(illegalCmd, 1'h0);
    drive(DBC_MODE_REG_READ, 3'h3, 1'h0);
    cmpBit(illegalCmd, 1'h0);
    cmpDev(devState, DBC_MR_READING);
    drive(DBC_NOP, 3'h0, 1'h0);
    drive(DBC_NOP, 3'h0, 1'h0);
    cmpDev(devState, DBC_NORMAL);
    cmpBit(allIdle, 1'h0);
    reqCmd = DBC_NOP;
    nrst = 1'h0;
    @(negedge mclk);
    cmpBit(allIdle, 1'h1);
    cmpDev(devState, DBC_POWER_ON);
    nrst = 1'h1;
    reqCmd = DBC_READ;
    lax = 1'h1;
    @(negedge mclk);
    cmpBit(illegalCmd, 1'h1);
    tally_and_finish();
  end
endmodule
